// ==== logic/cies_core.sv ====
// Purpose: execute a subset of 16-bit instruction words over four phases
// Assumes: fetch path presents the word and its address at decode phase
// Notes: unrecognised words run as a no-operation cycle
// Operation
// [RQ1] call: two cycles, push return address, load pc at last phase, then idle cycle
// [RQ2] 0010 100s ffff ffff clears file location, status flags untouched
// [RQ3] file clear also zeroes working register when select bit is 0
// [RQ4] 0000 0000 0000 0100 clears watchdog counter, sets timeout and powerdown flags
// [RQ5] watchdog clear resets postscaler in the same cycle as the counter
// [RQ6] compare-equal skips next fetched word with an idle cycle when equal
// [RQ7] compare-greater skips when file value exceeds working register
// [RQ8] compare-less skips when file value is below working register
// [RQ9] compares use unsigned file minus working register, store nothing, flags unchanged
// [RQ10] decimal adjust is one cycle on working register, updates carry only
// [RQ11] add 6 per nibble when above 9 or its carry is set
// [RQ12] adjust result goes to file, and working register when select bit 0
// [RQ13] decrement file, destination by bit, updates overflow, carry, digit carry, zero
// [RQ14] complement inverts file, destination by bit, updates only zero
`timescale 1ns/1ps
`default_nettype none
module cies_core
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // instruction fetch side
   input wire logic [15:0] i_instr,
   input wire logic [15:0] i_pc,
   output logic [1:0] o_phase,
   output logic o_skip,
   // program counter and stack
   output logic o_stack_push,
   output logic [15:0] o_stack_data,
   output logic o_pc_load,
   output logic [15:0] o_pc_value,
   // data memory
   output logic [7:0] o_file_addr,
   output logic o_file_re,
   input wire logic [7:0] i_file_rdata,
   output logic o_file_we,
   output logic [7:0] o_file_wdata,
   // watchdog and sleep status
   output logic o_watchdog_clear,
   output logic o_postscaler_clear,
   input wire logic i_timeout_flag_clr,
   input wire logic i_powerdown_flag_clr,
   output logic o_timeout_flag,
   output logic o_powerdown_flag,
   // core state
   output logic [7:0] o_working_register,
   output logic o_carry,
   output logic o_digit_carry,
   output logic o_zero,
   output logic o_overflow_flag
);

   cies_pkg::cies_phase_e phase, next_phase;
   cies_pkg::cies_op_e op, next_op;
   logic idle_cycle, next_idle_cycle;
   logic sel, next_sel;
   logic [7:0] file_addr, next_file_addr;
   logic [7:0] result, next_result;
   logic skip_req, next_skip_req;
   logic wr_file, next_wr_file;
   logic wr_work, next_wr_work;
   logic [3:0] flags_new, next_flags_new;
   logic [3:0] flags_upd, next_flags_upd;
   logic [15:0] stack_data, next_stack_data;
   logic [15:0] pc_value, next_pc_value;
   logic [7:0] working, next_working;
   logic carry, next_carry;
   logic digit_carry, next_digit_carry;
   logic zero, next_zero;
   logic overflow_flag, next_overflow_flag;
   logic timeout_flag, next_timeout_flag;
   logic powerdown_flag, next_powerdown_flag;

   function automatic logic hits(input logic [15:0] w, input logic [15:0] mask, input logic [15:0] match);
      hits = (w & mask) == match;
   endfunction
   function automatic logic digit_over(input logic [3:0] n);
      digit_over = n > cies_pkg::BCD_MAX_DIGIT;
   endfunction
   function automatic cies_pkg::cies_op_e decode(input logic [15:0] w);
      if (hits(w, cies_pkg::CALL_MASK, cies_pkg::CALL_MATCH))
         decode = cies_pkg::OP_CALL;
      else if (hits(w, cies_pkg::CLEAR_MASK, cies_pkg::CLEAR_MATCH))
         decode = cies_pkg::OP_FILE_CLEAR;
      else if (hits(w, cies_pkg::WATCHDOG_MASK, cies_pkg::WATCHDOG_MATCH))
         decode = cies_pkg::OP_WATCHDOG_CLEAR;
      else if (hits(w, cies_pkg::COMPL_MASK, cies_pkg::COMPL_MATCH))
         decode = cies_pkg::OP_FILE_COMPLEMENT;
      else if (hits(w, cies_pkg::CMP_MASK, cies_pkg::CMP_EQ_MATCH))
         decode = cies_pkg::OP_COMPARE_EQUAL;
      else if (hits(w, cies_pkg::CMP_MASK, cies_pkg::CMP_GT_MATCH))
         decode = cies_pkg::OP_COMPARE_GREATER;
      else if (hits(w, cies_pkg::CMP_MASK, cies_pkg::CMP_LT_MATCH))
         decode = cies_pkg::OP_COMPARE_LESS;
      else if (hits(w, cies_pkg::ADJ_MASK, cies_pkg::ADJ_MATCH))
         decode = cies_pkg::OP_DECIMAL_ADJUST;
      else if (hits(w, cies_pkg::DEC_MASK, cies_pkg::DEC_MATCH))
         decode = cies_pkg::OP_FILE_DECREMENT;
      else
         decode = cies_pkg::OP_NONE;
   endfunction

   // flag vector order: overflow, carry, digit carry, zero
   logic [8:0] diff, adj_sum;
   logic [7:0] adj_add, dec_val;

   always_comb
   begin
      diff = {1'b0, i_file_rdata} - {1'b0, working}; // [RQ9]
      adj_add[7:4] = (digit_over(working[7:4]) || carry) ? cies_pkg::BCD_FIX : 4'h0; // [RQ11]
      adj_add[3:0] = (digit_over(working[3:0]) || digit_carry) ? cies_pkg::BCD_FIX : 4'h0; // [RQ11]
      // lower digit carry ripples into the upper digit, giving the +7 case
      adj_sum = {1'b0, working} + {1'b0, adj_add};
      dec_val = i_file_rdata - 8'h01;
   end

   always_comb
   begin
      next_phase = phase;
      next_op = op;
      next_idle_cycle = idle_cycle;
      next_sel = sel;
      next_file_addr = file_addr;
      next_result = result;
      next_skip_req = skip_req;
      next_wr_file = wr_file;
      next_wr_work = wr_work;
      next_flags_new = flags_new;
      next_flags_upd = flags_upd;
      next_stack_data = stack_data;
      next_pc_value = pc_value;
      next_working = working;
      next_carry = carry;
      next_digit_carry = digit_carry;
      next_zero = zero;
      next_overflow_flag = overflow_flag;
      next_timeout_flag = i_timeout_flag_clr ? 1'b0 : timeout_flag;
      next_powerdown_flag = i_powerdown_flag_clr ? 1'b0 : powerdown_flag;
      unique case (phase)
         cies_pkg::PH_DECODE:
         begin
            next_phase = cies_pkg::PH_READ;
            // second cycle of call or skip ignores the word on the fetch bus
            next_op = idle_cycle ? cies_pkg::OP_NONE : decode(i_instr); // [RQ1] [RQ6]
            next_sel = i_instr[cies_pkg::SEL_BIT];
            next_file_addr = i_instr[cies_pkg::ADDR_MSB:0];
            next_stack_data = i_pc + 16'h0001; // [RQ1]
            next_pc_value = {i_pc[15:cies_pkg::PC_PAGE_LSB], i_instr[cies_pkg::CALL_LIT_MSB:0]};
            next_idle_cycle = 1'b0;
            next_skip_req = 1'b0;
            next_wr_file = 1'b0;
            next_wr_work = 1'b0;
            next_flags_upd = 4'h0;
         end
         cies_pkg::PH_READ:
            next_phase = cies_pkg::PH_PROCESS;
         cies_pkg::PH_PROCESS:
         begin
            next_phase = cies_pkg::PH_WRITE;
            unique case (op)
               cies_pkg::OP_FILE_CLEAR:
               begin
                  next_result = 8'h00; // [RQ2]
                  next_wr_file = 1'b1;
                  next_wr_work = !sel; // [RQ3]
               end
               cies_pkg::OP_WATCHDOG_CLEAR:
               begin
                  next_timeout_flag = 1'b1; // [RQ4]
                  next_powerdown_flag = 1'b1; // [RQ4]
               end
               cies_pkg::OP_FILE_COMPLEMENT:
               begin
                  next_result = ~i_file_rdata; // [RQ14]
                  next_wr_file = sel;
                  next_wr_work = !sel;
                  next_flags_new = {3'b000, ~i_file_rdata == 8'h00};
                  next_flags_upd = 4'b0001; // [RQ14]
               end
               cies_pkg::OP_COMPARE_EQUAL:
                  next_skip_req = diff == 9'h000; // [RQ6]
               cies_pkg::OP_COMPARE_GREATER:
                  next_skip_req = !diff[8] && diff != 9'h000; // [RQ7]
               cies_pkg::OP_COMPARE_LESS:
                  next_skip_req = diff[8]; // [RQ8]
               cies_pkg::OP_DECIMAL_ADJUST:
               begin
                  next_result = adj_sum[7:0]; // [RQ10]
                  next_wr_file = 1'b1; // [RQ12]
                  next_wr_work = !sel; // [RQ12]
                  next_flags_new = {1'b0, adj_sum[8], 2'b00};
                  next_flags_upd = 4'b0100; // [RQ10]
               end
               cies_pkg::OP_FILE_DECREMENT:
               begin
                  next_result = dec_val; // [RQ13]
                  next_wr_file = sel;
                  next_wr_work = !sel;
                  // carry and digit carry read as "no borrow"
                  next_flags_new = {i_file_rdata == 8'h80, i_file_rdata != 8'h00,
                                    i_file_rdata[3:0] != 4'h0, dec_val == 8'h00};
                  next_flags_upd = 4'b1111; // [RQ13]
               end
               default:
                  next_result = result;
            endcase
         end
         cies_pkg::PH_WRITE:
         begin
            next_phase = cies_pkg::PH_DECODE;
            next_idle_cycle = (op == cies_pkg::OP_CALL) || skip_req; // [RQ1] [RQ6] [RQ7] [RQ8]
            if (wr_work)
               next_working = result;
            next_overflow_flag = flags_upd[3] ? flags_new[3] : overflow_flag;
            next_carry = flags_upd[2] ? flags_new[2] : carry;
            next_digit_carry = flags_upd[1] ? flags_new[1] : digit_carry;
            next_zero = flags_upd[0] ? flags_new[0] : zero;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         phase <= cies_pkg::PH_DECODE;
         op <= cies_pkg::OP_NONE;
         idle_cycle <= 1'b0;
         sel <= 1'b0;
         file_addr <= 8'h00;
         result <= 8'h00;
         skip_req <= 1'b0;
         wr_file <= 1'b0;
         wr_work <= 1'b0;
         flags_new <= 4'h0;
         flags_upd <= 4'h0;
         stack_data <= 16'h0000;
         pc_value <= 16'h0000;
         working <= cies_pkg::WORKING_RESET;
         carry <= cies_pkg::ALU_FLAG_RESET;
         digit_carry <= cies_pkg::ALU_FLAG_RESET;
         zero <= cies_pkg::ALU_FLAG_RESET;
         overflow_flag <= cies_pkg::ALU_FLAG_RESET;
         timeout_flag <= cies_pkg::SLEEP_FLAG_RESET;
         powerdown_flag <= cies_pkg::SLEEP_FLAG_RESET;
      end
      else
      begin
         phase <= next_phase;
         op <= next_op;
         idle_cycle <= next_idle_cycle;
         sel <= next_sel;
         file_addr <= next_file_addr;
         result <= next_result;
         skip_req <= next_skip_req;
         wr_file <= next_wr_file;
         wr_work <= next_wr_work;
         flags_new <= next_flags_new;
         flags_upd <= next_flags_upd;
         stack_data <= next_stack_data;
         pc_value <= next_pc_value;
         working <= next_working;
         carry <= next_carry;
         digit_carry <= next_digit_carry;
         zero <= next_zero;
         overflow_flag <= next_overflow_flag;
         timeout_flag <= next_timeout_flag;
         powerdown_flag <= next_powerdown_flag;
      end
   end

   logic reads_file;
   assign reads_file = (op != cies_pkg::OP_NONE) && (op != cies_pkg::OP_CALL) && (op != cies_pkg::OP_WATCHDOG_CLEAR);
   assign o_phase = phase;
   assign o_skip = (phase == cies_pkg::PH_WRITE) && skip_req; // [RQ6] [RQ7] [RQ8]
   assign o_stack_push = (phase == cies_pkg::PH_READ) && (op == cies_pkg::OP_CALL); // [RQ1]
   assign o_stack_data = stack_data;
   assign o_pc_load = (phase == cies_pkg::PH_WRITE) && (op == cies_pkg::OP_CALL); // [RQ1]
   assign o_pc_value = pc_value;
   assign o_file_addr = file_addr;
   assign o_file_re = (phase == cies_pkg::PH_READ) && reads_file;
   assign o_file_we = (phase == cies_pkg::PH_WRITE) && wr_file; // [RQ2] [RQ12]
   assign o_file_wdata = result;
   // counter and postscaler share one pulse so neither can lag the other
   assign o_watchdog_clear = (phase == cies_pkg::PH_PROCESS) && (op == cies_pkg::OP_WATCHDOG_CLEAR); // [RQ4]
   assign o_postscaler_clear = o_watchdog_clear; // [RQ5]
   assign o_timeout_flag = timeout_flag;
   assign o_powerdown_flag = powerdown_flag;
   assign o_working_register = working;
   assign o_carry = carry;
   assign o_digit_carry = digit_carry;
   assign o_zero = zero;
   assign o_overflow_flag = overflow_flag;
endmodule
`default_nettype wire

// ==== logic/cies_pkg.sv ====
// Purpose: shared constants and types of the instruction execute subset
// Assumes: 16-bit instruction words, 8-bit data path, four phases per instruction cycle
// Notes: opcode patterns are held as mask and match pairs
package cies_pkg;

   // instruction field layout
   localparam int SEL_BIT = 8;
   localparam int ADDR_MSB = 7;
   localparam int CALL_LIT_MSB = 12;
   localparam int PC_PAGE_LSB = 13;

   // opcode patterns: (instr & mask) == match
   localparam logic [15:0] CALL_MASK = 16'he000;
   localparam logic [15:0] CALL_MATCH = 16'he000;
   localparam logic [15:0] CLEAR_MASK = 16'hfe00;
   localparam logic [15:0] CLEAR_MATCH = 16'h2800;
   localparam logic [15:0] WATCHDOG_MASK = 16'hffff;
   localparam logic [15:0] WATCHDOG_MATCH = 16'h0004;
   localparam logic [15:0] COMPL_MASK = 16'hfe00;
   localparam logic [15:0] COMPL_MATCH = 16'h1200;
   localparam logic [15:0] CMP_MASK = 16'hff00;
   localparam logic [15:0] CMP_EQ_MATCH = 16'h3100;
   localparam logic [15:0] CMP_GT_MATCH = 16'h3200;
   localparam logic [15:0] CMP_LT_MATCH = 16'h3000;
   localparam logic [15:0] ADJ_MASK = 16'hfe00;
   localparam logic [15:0] ADJ_MATCH = 16'h2e00;
   localparam logic [15:0] DEC_MASK = 16'hfe00;
   localparam logic [15:0] DEC_MATCH = 16'h0600;

   // decimal adjust figures
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;

   // reset values
   localparam logic [7:0] WORKING_RESET = 8'h00;
   localparam logic ALU_FLAG_RESET = 1'b0;
   localparam logic SLEEP_FLAG_RESET = 1'b1;

   // timing: phases per instruction cycle, cycles of a call
   localparam int PHASES_PER_CYCLE = 4;
   localparam int CALL_CYCLES = 2;

   typedef enum logic [1:0] {
      PH_DECODE,
      PH_READ,
      PH_PROCESS,
      PH_WRITE
   } cies_phase_e;

   typedef enum logic [3:0] {
      OP_NONE,
      OP_CALL,
      OP_FILE_CLEAR,
      OP_WATCHDOG_CLEAR,
      OP_FILE_COMPLEMENT,
      OP_COMPARE_EQUAL,
      OP_COMPARE_GREATER,
      OP_COMPARE_LESS,
      OP_DECIMAL_ADJUST,
      OP_FILE_DECREMENT
   } cies_op_e;

endpackage

// ==== test/cies_core_sva.sv ====
// Purpose: concurrent checks on the execute subset core ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: idle cycles after call and skip are watched for four clocks
`timescale 1ns/1ps
`default_nettype none
module cies_core_sva
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // sequencing
   input wire logic [1:0] o_phase,
   input wire logic o_skip,
   input wire logic o_stack_push,
   input wire logic o_pc_load,
   // data memory strobes
   input wire logic o_file_re,
   input wire logic o_file_we,
   // watchdog
   input wire logic o_watchdog_clear,
   input wire logic o_postscaler_clear,
   input wire logic o_timeout_flag,
   input wire logic o_powerdown_flag,
   // status
   input wire logic o_carry,
   input wire logic o_digit_carry,
   input wire logic o_zero,
   input wire logic o_overflow_flag
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   a_push_then_load: assert property (o_stack_push |-> o_phase == 2'h1 ##2 o_pc_load)
      else $error("stack push not followed by pc load");
   a_call_idle_cycle: assert property (o_pc_load |=> (!o_file_we && !o_file_re && !o_stack_push) [*4])
      else $error("activity in the idle cycle after a call");
   a_skip_idle_cycle: assert property (o_skip |-> o_phase == 2'h3 ##1 (!o_file_we && !o_file_re && !o_skip) [*4])
      else $error("activity in the idle cycle after a skip");
   a_skip_keeps_flags: assert property (o_skip |=> $stable(o_carry) && $stable(o_zero) && $stable(o_digit_carry) && $stable(o_overflow_flag))
      else $error("compare changed a status flag");
   a_write_phase_only: assert property (o_file_we |-> o_phase == 2'h3 && !o_skip)
      else $error("file write outside phase 3 or during a skip");
   a_read_before_write: assert property (o_file_we |-> $past(o_file_re, 2))
      else $error("file write without read two clocks earlier");
   a_postscaler_pair: assert property ((o_watchdog_clear || o_postscaler_clear) |-> o_watchdog_clear && o_postscaler_clear && o_phase == 2'h2)
      else $error("postscaler clear not with watchdog clear");
   a_watchdog_flags: assert property (o_watchdog_clear |-> o_phase == 2'h2 ##1 (o_timeout_flag && o_powerdown_flag))
      else $error("watchdog clear did not set both sleep flags");
endmodule
bind cies_core cies_core_sva i_cies_core_sva (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .o_phase(o_phase),
   .o_skip(o_skip), .o_stack_push(o_stack_push), .o_pc_load(o_pc_load), .o_file_re(o_file_re),
   .o_file_we(o_file_we), .o_watchdog_clear(o_watchdog_clear), .o_postscaler_clear(o_postscaler_clear),
   .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag), .o_carry(o_carry),
   .o_digit_carry(o_digit_carry), .o_zero(o_zero), .o_overflow_flag(o_overflow_flag));
`default_nettype wire

// ==== test/cies_core_tb_top.sv ====
// Purpose: self-checking bench for the execute subset core
// Assumes: words are offered at phase 0, one per four clocks
// Notes: the working register is loaded through complement to keep setup short
`timescale 1ns/1ps
`default_nettype none
module cies_core_tb_top;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [15:0] i_instr = 16'h0000;
   logic [15:0] i_pc = 16'h0100;
   logic [7:0] i_file_rdata = 8'h00;
   logic i_timeout_flag_clr = 1'b0;
   logic i_powerdown_flag_clr = 1'b0;
   logic [1:0] o_phase;
   logic o_skip, o_stack_push, o_pc_load, o_file_re, o_file_we, o_watchdog_clear, o_postscaler_clear;
   logic o_timeout_flag, o_powerdown_flag, o_carry, o_digit_carry, o_zero, o_overflow_flag;
   logic [15:0] o_stack_data, o_pc_value;
   logic [7:0] o_file_addr, o_file_wdata, o_working_register;
   logic c_push, c_load, c_we, c_wd, c_ps, c_skip, c_re;
   logic [7:0] c_wdata;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;

   cies_core i_cies_core (.i_ref_clk, .i_rst_b, .i_instr, .i_pc, .o_phase, .o_skip, .o_stack_push,
      .o_stack_data, .o_pc_load, .o_pc_value, .o_file_addr, .o_file_re, .i_file_rdata, .o_file_we,
      .o_file_wdata, .o_watchdog_clear, .o_postscaler_clear, .i_timeout_flag_clr, .i_powerdown_flag_clr,
      .o_timeout_flag, .o_powerdown_flag, .o_working_register, .o_carry, .o_digit_carry, .o_zero,
      .o_overflow_flag);

   always #2 i_ref_clk = ~i_ref_clk;

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // run takes 4 clocks per word; 28 words in all, about 130 clocks against the 5000-clock limit
   always @(posedge i_ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         test_done();
      end
   end

   // wide enough for the longest packed comparison
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [3:0] flg();
      return {o_carry, o_digit_carry, o_zero, o_overflow_flag};
   endfunction

   // entered at phase 0, returns at the next phase 0 with results settled
   task automatic run(input logic [15:0] ins, input logic [7:0] rd);
      i_instr = ins;
      i_file_rdata = rd;
      {c_push, c_load, c_we, c_wd, c_ps, c_skip, c_re} = 7'h00;
      repeat (4)
      begin
         @(posedge i_ref_clk);
         #1;
         c_push |= o_stack_push;
         c_load |= o_pc_load;
         c_we |= o_file_we;
         c_wd |= o_watchdog_clear;
         c_ps |= o_postscaler_clear;
         c_skip |= o_skip;
         c_re |= o_file_re;
         if (o_phase === 2'h3)
            c_wdata = o_file_wdata;
      end
   endtask

   task automatic t_compl_clear;
      run(16'h1322, 8'hff);
      chk("compl file", {c_we, c_re, c_wdata, o_working_register, flg()}, {2'h3, 8'h00, 8'h00, 4'h2});
      run(16'h1211, 8'hc3);
      chk("compl w", {c_we, o_working_register, flg()}, {1'b0, 8'h3c, 4'h0});
      run(16'h2955, 8'ha5);
      chk("clear s1", {c_we, c_wdata, o_file_addr, o_working_register, flg()}, {9'h100, 8'h55, 8'h3c, 4'h0});
      run(16'h2866, 8'h11);
      chk("clear s0", {c_we, c_wdata, o_working_register, flg()}, {1'b1, 8'h00, 8'h00, 4'h0});
      $display("test complement and clear done");
   endtask

   task automatic t_call;
      i_pc = 16'h4010;
      run(16'he123, 8'h00);
      chk("call push", {c_push, c_load, o_stack_data}, {2'h3, 16'h4011});
      chk("call pc", o_pc_value, 16'h4123);
      i_pc = 16'h0100;
      run(16'h1200, 8'h00);
      chk("call idle", {c_we, o_working_register}, {1'b0, 8'h00});
      $display("test call done");
   endtask

   task automatic t_watchdog;
      i_timeout_flag_clr = 1'b1;
      i_powerdown_flag_clr = 1'b1;
      // an undecoded word, so the following cycle is not an idle one
      run(16'h0000, 8'h00);
      i_timeout_flag_clr = 1'b0;
      i_powerdown_flag_clr = 1'b0;
      chk("flags cleared", {o_timeout_flag, o_powerdown_flag}, 2'h0);
      run(16'h0004, 8'h00);
      chk("watchdog", {c_wd, c_ps, c_we, c_re, o_timeout_flag, o_powerdown_flag}, 6'h33);
      $display("test watchdog done");
   endtask

   // 0x80 above 0x7f only when compared unsigned
   task automatic t_compare;
      logic [3:0] f;
      logic e;
      // decrement of 0x80 leaves carry and overflow set, so a flag change shows
      run(16'h0644, 8'h80);
      for (int op = 0; op < 3; op++)
         for (int j = 0; j < 3; j++)
         begin
            f = flg();
            e = (op == j);
            run({8'h30 + 8'(op), 8'h44}, 8'h7e + 8'(j));
            chk("cmp skip", {c_skip, c_we, o_working_register, flg()}, {e, 1'b0, 8'h7f, f});
            if (e)
            begin
               run(16'h1200, 8'h00);
               chk("skip idle", {c_we, o_working_register}, {1'b0, 8'h7f});
            end
         end
      $display("test compare done");
   endtask

   task automatic t_adjust_dec;
      run(16'h0710, 8'h00);
      chk("dec zero", {c_we, c_wdata, flg()}, {1'b1, 8'hff, 4'h0});
      run(16'h1200, 8'h5a);
      run(16'h2e30, 8'h00);
      chk("adj s0", {c_we, c_wdata, o_working_register, o_carry}, {1'b1, 8'h05, 8'h05, 1'b1});
      run(16'h0710, 8'h01);
      chk("dec one", {c_wdata, flg()}, {8'h00, 4'he});
      run(16'h1200, 8'hed);
      run(16'h2f31, 8'h00);
      chk("adj s1", {c_we, c_wdata, o_working_register, flg()}, {1'b1, 8'h78, 8'h12, 4'h4});
      run(16'h0640, 8'h80);
      chk("dec w", {c_we, o_working_register, flg()}, {1'b0, 8'h7f, 4'h9});
      $display("test adjust and decrement done");
   endtask

   initial
   begin
      repeat (16) @(posedge i_ref_clk);
      #1;
      i_rst_b = 1'b1;
      t_compl_clear();
      t_call();
      t_watchdog();
      t_compare();
      t_adjust_dec();
      test_done();
   end
endmodule
`default_nettype wire
